/* File: common/psc_pkg.sv */
// shared constants for the program security controller
package psc_pkg;
  // register addresses
  localparam logic [7:0] PSC_SFR_FLASH_CONTROL = 8'hb2;
  localparam logic [15:0] PSC_X_TRIM_BURN = 16'hffd1;
  localparam logic [15:0] PSC_X_FUSE_SELECT = 16'hffd2;
  localparam logic [15:0] PSC_X_SECURITY_STATUS = 16'hffd7;
  // field positions
  localparam int PSC_FC_PROTECT_BIT = 6;
  localparam int PSC_SS_BURN_ARM_BIT = 7;
  localparam int PSC_SS_PIN_BIT = 5;
  localparam int PSC_SS_L0_BIT = 1;
  localparam int PSC_SS_L1_BIT = 0;
  // sequence codes
  localparam logic [7:0] PSC_CODE_SETUP = 8'h54;
  localparam logic [7:0] PSC_CODE_SEL_L0 = 8'h81;
  localparam logic [7:0] PSC_CODE_SEL_L1 = 8'h82;
  localparam logic [7:0] PSC_CODE_BURN = 8'ha6;
  // reset values
  localparam logic [7:0] PSC_RST_BYTE = 8'h00;
  // burn time and cycles at 125 MHz
  localparam int PSC_BURN_TIME_US = 500;
  localparam int PSC_CLK_MHZ = 125;
  localparam int PSC_BURN_CYCLES = PSC_BURN_TIME_US * PSC_CLK_MHZ;
  // flash page zero ends at this byte address, which it includes
  localparam logic [15:0] PSC_PAGE0_LAST = 16'h01ff;
  // burn sequencer states
  typedef enum logic [3:0] {
    PSC_IDLE = 4'h1,
    PSC_SETUP = 4'h2,
    PSC_SELECTED = 4'h4,
    PSC_BURNING = 4'h8
  } psc_burn_e;
endpackage

/* File: logic/psc_security_ctrl.sv */
// program security controller: protect bit, fuses, debug and flash gating
//
// Contract
// - protect bit at flash control bit 6
// - protected debug port does only bulk erase
// - protect bit cleared at reset, set-only
// - level 0 needs level-0 fuse blown
// - blown fuses are permanent, never overridden
// - leave level 0 via global erase, reset; the code ends level 0 on reset alone
// - global erase also clears external RAM
// - protected: refuse external flash, RAM reads
// - protected: refuse page-zero page erase
// - protected: inhibit writes to page zero
// - level-1 fuse disables debug port forever
// - level-1 fuse sampled during reset
// - level-0 burn ignores security pin
// - security pin readable at status bit 5
// - fuse blows only after ordered code writes
`timescale 1ns/1ps
module psc_security_ctrl
  import psc_pkg::*;
#(
  parameter int BURN_CYCLES = PSC_BURN_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst_b,
  // processor special register port
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // processor external-space register port
  input wire logic xreg_wr,
  input wire logic xreg_rd,
  input wire logic [15:0] xreg_addr,
  input wire logic [7:0] xreg_wdata,
  output logic [7:0] xreg_rdata,
  // security enable pin, asynchronous
  input wire logic security_pin,
  // fuse cells: sensed state and burn drive
  input wire logic level0_fuse,
  input wire logic level1_fuse,
  output logic level0_burn,
  output logic level1_burn,
  // flash requests from processor and debug port
  input wire logic cpu_page_erase,
  input wire logic cpu_flash_write,
  input wire logic [15:0] cpu_flash_addr,
  input wire logic dbg_req,
  input wire logic dbg_global_erase,
  input wire logic dbg_page_erase,
  input wire logic dbg_flash_write,
  input wire logic dbg_ext_read,
  input wire logic [15:0] dbg_flash_addr,
  input wire logic global_erase_done,
  // gated results
  output logic debug_port_enable,
  output logic dbg_req_ok,
  output logic cpu_page_erase_ok,
  output logic cpu_flash_write_ok,
  output logic dbg_page_erase_ok,
  output logic dbg_flash_write_ok,
  output logic dbg_ext_read_ok,
  output logic global_erase_ok,
  output logic xram_clear,
  output logic protect_active
);

  logic protect_q;
  logic burn_arm_q;
  logic [7:0] fuse_sel_q;
  logic [7:0] trim_q;
  logic pin_s1_q, pin_s2_q;
  logic l0_s1_q, l0_s2_q, l1_s1_q, l1_s2_q;
  logic l1_latched_q;
  logic l1_sampled_q;
  logic [31:0] burn_cnt_q;
  psc_burn_e burn_q;
  logic page0_cpu, page0_dbg;
  logic dbg_on;

  wire fc_wr = sfr_wr && (sfr_addr == PSC_SFR_FLASH_CONTROL);
  wire ts_wr = xreg_wr && (xreg_addr == PSC_X_TRIM_BURN);
  wire fs_wr = xreg_wr && (xreg_addr == PSC_X_FUSE_SELECT);
  wire ss_wr = xreg_wr && (xreg_addr == PSC_X_SECURITY_STATUS);

  // security pin synchroniser; the pin idles low through its pull-down,
  // so a reset value of zero matches its idle level
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
    end else begin
      pin_s1_q <= security_pin;
      pin_s2_q <= pin_s1_q;
    end
  end

  // level-0 fuse sense synchroniser; the cell is a slow static level,
  // two flops keep metastability out of the gating logic
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      l0_s1_q <= 1'b0;
      l0_s2_q <= 1'b0;
    end else begin
      l0_s1_q <= level0_fuse;
      l0_s2_q <= l0_s1_q;
    end
  end

  // level-1 fuse sense synchroniser keeps running through reset, so the
  // value is settled by the time reset ends; a reset here would hide a
  // blown fuse for two cycles after release
  always_ff @(posedge core_clk) begin
    l1_s1_q <= level1_fuse;
    l1_s2_q <= l1_s1_q;
  end

  // level-1 fuse is captured while reset is held, before the core may
  // fetch a single instruction; outside reset it only holds, so no
  // register write can reach it
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      l1_sampled_q <= l1_s2_q;
    end
  end

  // a burn of the level-1 fuse disables the port at once, not next reset;
  // the latch also catches a fuse that reads blown after reset ended
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      l1_latched_q <= 1'b0;
    end else if (l1_s2_q || level1_burn) begin
      l1_latched_q <= 1'b1;
    end
  end

  // protect bit: set-only, cleared by reset alone; since a full reset
  // is the only clear, level 0 ends at any reset, with or without an erase
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      protect_q <= 1'b0;
    end else if (fc_wr && sfr_wdata[PSC_FC_PROTECT_BIT]) begin
      protect_q <= 1'b1;
    end
  end

  // burn arm bit in the security status register; without it no code
  // sequence can drive a fuse, a second guard against stray writes
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      burn_arm_q <= 1'b0;
    end else if (ss_wr) begin
      burn_arm_q <= xreg_wdata[PSC_SS_BURN_ARM_BIT];
    end
  end

  // write-only sequence registers; kept so the last written codes are
  // visible to a debugger on the internal nets, never read back
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      trim_q <= PSC_RST_BYTE;
      fuse_sel_q <= PSC_RST_BYTE;
    end else begin
      if (ts_wr) begin
        trim_q <= xreg_wdata;
      end
      if (fs_wr) begin
        fuse_sel_q <= xreg_wdata;
      end
    end
  end

  // burn sequencer: setup code, then one level code, then burn code;
  // any other value but a repeated setup or burn code aborts, which also stops a burn in progress;
  // codes are taken at either control register, so firmware that
  // swaps the two registers still reaches the same sequence
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      burn_q <= PSC_IDLE;
    end else begin
      case (burn_q)
        PSC_IDLE: begin
          if (xreg_wr && (ts_wr || fs_wr) &&
              xreg_wdata == PSC_CODE_SETUP) begin
            burn_q <= PSC_SETUP;
          end
        end
        PSC_SETUP: begin
          if (xreg_wr && (ts_wr || fs_wr)) begin
            if (xreg_wdata == PSC_CODE_SEL_L0 ||
                xreg_wdata == PSC_CODE_SEL_L1) begin
              burn_q <= PSC_SELECTED;
            end else if (xreg_wdata != PSC_CODE_SETUP) begin
              burn_q <= PSC_IDLE;
            end
          end
        end
        PSC_SELECTED: begin
          if (xreg_wr && (ts_wr || fs_wr)) begin
            if (xreg_wdata == PSC_CODE_BURN) begin
              burn_q <= PSC_BURNING;
            end else begin
              burn_q <= PSC_IDLE;
            end
          end
        end
        PSC_BURNING: begin
          if (xreg_wr && (ts_wr || fs_wr) &&
              xreg_wdata != PSC_CODE_BURN) begin
            burn_q <= PSC_IDLE;
          end
        end
        default: burn_q <= PSC_IDLE;
      endcase
    end
  end

  // remember which level was selected for this burn; it is taken in the
  // setup state only, a second select code aborts the sequence
  logic sel_l1_q;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sel_l1_q <= 1'b0;
    end else if (burn_q == PSC_SETUP && xreg_wr && (ts_wr || fs_wr)) begin
      if (xreg_wdata == PSC_CODE_SEL_L1) begin
        sel_l1_q <= 1'b1;
      end else if (xreg_wdata == PSC_CODE_SEL_L0) begin
        sel_l1_q <= 1'b0;
      end
    end
  end

  // burn timer caps the drive time so a stuck sequence cannot overheat;
  // firmware that forgets the closing zero writes still ends the drive,
  // at the price of a burn no longer than the timer allows
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      burn_cnt_q <= 32'h0000_0000;
    end else if (burn_q != PSC_BURNING) begin
      burn_cnt_q <= 32'h0000_0000;
    end else if (burn_cnt_q < 32'(BURN_CYCLES)) begin
      burn_cnt_q <= burn_cnt_q + 32'h0000_0001;
    end
  end

  wire burning = (burn_q == PSC_BURNING) && burn_arm_q &&
                 (burn_cnt_q < 32'(BURN_CYCLES));

  // fuse drives: level 1 needs the pin high, level 0 does not; the pin
  // is taken through its synchroniser, so a glitch cannot start a burn
  always_comb begin
    level0_burn = burning && !sel_l1_q;
    level1_burn = burning && sel_l1_q && pin_s2_q;
  end

  // protection state; fuse states come only from the cells, so a write
  // can neither fake a blown fuse nor hide one; the live burn drive
  // also shuts the port so the disable is immediate
  always_comb begin
    protect_active = protect_q && l0_s2_q;
    dbg_on = !(l1_sampled_q || l1_latched_q || level1_burn);
    debug_port_enable = dbg_on;
    page0_cpu = cpu_flash_addr <= PSC_PAGE0_LAST;
    page0_dbg = dbg_flash_addr <= PSC_PAGE0_LAST;
  end

  // request gating for processor and debug port; every gate is pure
  // logic on levels, so a request is judged in the cycle it is raised
  // and a refused request never reaches the flash controller

  // the debug port keeps the bulk erase even when protected, since
  // that erase is the only way to clear the code; level 0 itself ends at any reset, erase or not
  always_comb begin
    global_erase_ok = dbg_on && dbg_global_erase;
    dbg_req_ok = dbg_on && dbg_req &&
                 (!protect_active || dbg_global_erase);
  end

  // external reads of code and data are shut while protected
  always_comb begin
    dbg_ext_read_ok = dbg_on && dbg_ext_read &&
                      !protect_active;
  end

  // page zero holds the pre-boot code; the processor keeps the rest of
  // the array while protected, the debug port loses all of it
  always_comb begin
    cpu_page_erase_ok = cpu_page_erase &&
                        !(protect_active && page0_cpu);
    dbg_page_erase_ok = dbg_on && dbg_page_erase && !protect_active &&
                        !(protect_active && page0_dbg);
    cpu_flash_write_ok = cpu_flash_write &&
                         !(protect_active && page0_cpu);
    dbg_flash_write_ok = dbg_on && dbg_flash_write && !protect_active &&
                         !(protect_active && page0_dbg);
  end

  // a finished global erase wipes the data RAM, protected or not
  always_comb begin
    xram_clear = global_erase_done;
  end

  // flash control readback, one cycle after the strobe: only the
  // protect bit lives here, the other bits belong to the flash
  // controller and read as zero from this block
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sfr_rdata <= PSC_RST_BYTE;
    end else begin
      sfr_rdata <= PSC_RST_BYTE;
      if (sfr_rd && sfr_addr == PSC_SFR_FLASH_CONTROL) begin
        sfr_rdata[PSC_FC_PROTECT_BIT] <= protect_q;
      end
    end
  end

  // security status readback: pin at bit 5, level-0 fuse at bit 1,
  // level-1 fuse at bit 0; the arm bit is write-only and reads zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      xreg_rdata <= PSC_RST_BYTE;
    end else begin
      xreg_rdata <= PSC_RST_BYTE;
      if (xreg_rd && xreg_addr == PSC_X_SECURITY_STATUS) begin
        xreg_rdata[PSC_SS_PIN_BIT] <= pin_s2_q;
        xreg_rdata[PSC_SS_L0_BIT] <= l0_s2_q;
        xreg_rdata[PSC_SS_L1_BIT] <= l1_s2_q;
      end
    end
  end

endmodule

/* File: verif/psc_fuse_model.sv */
// fuse cell model standing behind the burn drive outputs
`timescale 1ns/1ps
module psc_fuse_model #(
  parameter int BLOW_CYCLES = 4
) (
  input wire logic core_clk,
  input wire logic security_pin,
  input wire logic level0_burn,
  input wire logic level1_burn,
  output logic level0_fuse = 1'b0,
  output logic level1_fuse = 1'b0
);
  int cnt0 = 0;
  int cnt1 = 0;
  // level 1 drive only counts with the pin high; level 0 ignores the pin
  always @(posedge core_clk) begin
    cnt0 <= level0_burn ? cnt0 + 1 : 0;
    cnt1 <= (level1_burn && security_pin) ? cnt1 + 1 : 0;
    // a blown cell never heals, so there is no reset here
    if (cnt0 >= BLOW_CYCLES) level0_fuse <= 1'b1;
    if (cnt1 >= BLOW_CYCLES) level1_fuse <= 1'b1;
  end
endmodule

/* File: verif/psc_security_assertions.sv */
// concurrent checks on the security controller ports
`timescale 1ns/1ps
module psc_security_assertions
  import psc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic xreg_wr,
  input wire logic [7:0] xreg_wdata,
  input wire logic [15:0] cpu_flash_addr,
  input wire logic global_erase_done,
  input wire logic xram_clear,
  input wire logic protect_active,
  input wire logic dbg_ext_read_ok,
  input wire logic cpu_page_erase_ok,
  input wire logic cpu_flash_write_ok,
  input wire logic dbg_page_erase_ok,
  input wire logic dbg_flash_write_ok,
  input wire logic level0_burn,
  input wire logic level1_burn,
  input wire logic debug_port_enable
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  chk_xram_clear_follow: assert property (
    global_erase_done |-> xram_clear) else $error("xram clear missing");
  chk_protect_stays_set: assert property (
    protect_active |=> protect_active) else $error("protect dropped");
  chk_ext_read_block: assert property (
    protect_active |-> !dbg_ext_read_ok) else $error("read passed");
  chk_cpu_page0_erase: assert property (
    protect_active && cpu_flash_addr <= PSC_PAGE0_LAST |-> !cpu_page_erase_ok)
    else $error("page zero erase passed");
  chk_cpu_page0_write: assert property (
    protect_active && cpu_flash_addr <= PSC_PAGE0_LAST |-> !cpu_flash_write_ok)
    else $error("page zero write passed");
  chk_dbg_erase_block: assert property (
    protect_active |-> !dbg_page_erase_ok) else $error("debug erase passed");
  chk_dbg_write_block: assert property (
    protect_active |-> !dbg_flash_write_ok) else $error("debug write passed");
  chk_burn_after_code: assert property (
    $rose(level0_burn || level1_burn) |->
      $past(xreg_wr && xreg_wdata == PSC_CODE_BURN)) else $error("early burn");
  chk_l1_burn_debug: assert property (
    level1_burn |-> !debug_port_enable) else $error("debug on in burn");
endmodule
bind psc_security_ctrl psc_security_assertions u_psc_security_assertions (.*);

/* File: verif/test_program_security_controller.sv */
// self-checking bench for the program security controller
`timescale 1ns/1ps
module test_program_security_controller;
  import psc_pkg::*;
  logic core_clk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, xreg_wr = 0;
  logic xreg_rd = 0, security_pin = 1, cpu_page_erase = 0, dbg_req = 0;
  logic cpu_flash_write = 0, dbg_global_erase = 0, dbg_page_erase = 0;
  logic dbg_flash_write = 0, dbg_ext_read = 0, global_erase_done = 0;
  logic [7:0] sfr_addr = PSC_SFR_FLASH_CONTROL, sfr_wdata = 8'h00;
  logic [7:0] xreg_wdata = 8'h00, sfr_rdata, xreg_rdata, rd;
  logic [15:0] xreg_addr = 16'h0000, cpu_flash_addr = 16'h0000;
  logic [15:0] dbg_flash_addr = 16'h0000;
  logic level0_fuse, level1_fuse, level0_burn, level1_burn, xram_clear;
  logic debug_port_enable, dbg_req_ok, cpu_page_erase_ok, global_erase_ok;
  logic cpu_flash_write_ok, dbg_page_erase_ok, dbg_flash_write_ok;
  logic dbg_ext_read_ok, protect_active;
  int errors = 0, num_checks = 0;
  always #4 core_clk = ~core_clk;
  // short burn so the run stays brief
  psc_security_ctrl #(.BURN_CYCLES(20)) u_psc_security_ctrl (.*);
  psc_fuse_model u_psc_fuse_model (.*);
  task automatic check8(string what, logic [7:0] exp, logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  // strobes rise and fall on falling edges, one sampling edge apart
  task automatic xwr(logic [15:0] a, logic [7:0] d);
    @(negedge core_clk);
    {xreg_addr, xreg_wdata, xreg_wr} = {a, d, 1'b1};
    @(negedge core_clk);
    xreg_wr = 0;
  endtask
  task automatic xrd(logic [15:0] a);
    @(negedge core_clk);
    {xreg_addr, xreg_rd} = {a, 1'b1};
    @(negedge core_clk);
    xreg_rd = 0;
    rd = xreg_rdata;
  endtask
  task automatic swr(logic [7:0] d);
    @(negedge core_clk);
    {sfr_wdata, sfr_wr} = {d, 1'b1};
    @(negedge core_clk);
    sfr_wr = 0;
  endtask
  task automatic srd();
    @(negedge core_clk);
    sfr_rd = 1;
    @(negedge core_clk);
    sfr_rd = 0;
    rd = sfr_rdata;
  endtask
  task automatic do_reset();
    @(negedge core_clk);
    rst_b = 0;
    repeat (2) @(negedge core_clk);
    rst_b = 1;
    repeat (3) @(negedge core_clk);
  endtask
  // full burn walk, then the fuse sense needs a few edges to settle
  task automatic burn(logic [7:0] code);
    xwr(PSC_X_SECURITY_STATUS, 8'h80);
    xwr(PSC_X_TRIM_BURN, PSC_CODE_SETUP);
    xwr(PSC_X_FUSE_SELECT, code);
    xwr(PSC_X_TRIM_BURN, PSC_CODE_BURN);
    #1 check8("burn_drive", 1, level0_burn || level1_burn);
    repeat (30) @(negedge core_clk);
    xwr(PSC_X_TRIM_BURN, 8'h00);
    xwr(PSC_X_FUSE_SELECT, 8'h00);
    repeat (4) @(negedge core_clk);
  endtask
  task automatic t_unfused();
    srd();
    check8("flash_control", 8'h00, rd);
    xrd(PSC_X_SECURITY_STATUS);
    check8("security_status", 8'h20, rd);
    xrd(16'hffd0);
    check8("unmapped", 8'h00, rd);
    swr(8'h40);
    srd();
    check8("flash_control", 8'h40, rd);
    {dbg_req, dbg_ext_read} = 2'b11;
    #1 check8("protect_active", 0, protect_active);
    check8("dbg_ext_read_ok", 1, dbg_ext_read_ok);
  endtask
  task automatic t_level0();
    security_pin = 0;
    burn(PSC_CODE_SEL_L0);
    xrd(PSC_X_SECURITY_STATUS);
    check8("security_status", 8'h02, rd);
    swr(8'h00);
    {cpu_page_erase, cpu_flash_write, cpu_flash_addr} =
      {2'b11, PSC_PAGE0_LAST};
    #1 check8("protect_active", 1, protect_active);
    check8("dbg_ext_read_ok", 0, dbg_ext_read_ok);
    check8("cpu_page_erase_ok", 0, cpu_page_erase_ok);
    check8("cpu_flash_write_ok", 0, cpu_flash_write_ok);
    check8("dbg_req_ok", 0, dbg_req_ok);
    @(negedge core_clk);
    cpu_flash_addr = 16'h0200;
    {dbg_ext_read, dbg_flash_write, dbg_global_erase} = 3'b011;
    dbg_page_erase = 1;
    #1 check8("cpu_page_erase_ok", 1, cpu_page_erase_ok);
    check8("cpu_flash_write_ok", 1, cpu_flash_write_ok);
    check8("dbg_page_erase_ok", 0, dbg_page_erase_ok);
    check8("dbg_req_ok", 1, dbg_req_ok);
    check8("dbg_flash_write_ok", 0, dbg_flash_write_ok);
    check8("global_erase_ok", 1, global_erase_ok);
    @(negedge core_clk);
    {global_erase_done, cpu_page_erase, dbg_flash_write} = 3'b100;
    {cpu_flash_write, dbg_page_erase} = 2'b00;
    #1 check8("xram_clear", 1, xram_clear);
    @(negedge core_clk);
    {global_erase_done, dbg_global_erase} = 2'b00;
  endtask
  task automatic t_recover();
    do_reset();
    dbg_ext_read = 1;
    {dbg_page_erase, cpu_flash_write, cpu_flash_addr} = {2'b11, 16'h0000};
    #1 check8("protect_active", 0, protect_active);
    check8("dbg_page_erase_ok", 1, dbg_page_erase_ok);
    check8("cpu_flash_write_ok", 1, cpu_flash_write_ok);
    check8("dbg_ext_read_ok", 1, dbg_ext_read_ok);
    check8("debug_port_enable", 1, debug_port_enable);
  endtask
  task automatic t_level1();
    security_pin = 1;
    burn(PSC_CODE_SEL_L1);
    check8("debug_port_enable", 0, debug_port_enable);
    do_reset();
    check8("debug_port_enable", 0, debug_port_enable);
    xrd(PSC_X_SECURITY_STATUS);
    check8("security_status", 8'h23, rd);
  endtask
  task automatic wrap_up();
    if (errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    do_reset();
    t_unfused();
    t_level0();
    t_recover();
    t_level1();
    wrap_up();
  end
  // about 130 cycles are expected; allow generous slack
  initial begin
    #50000;
    errors++;
    wrap_up();
  end
endmodule
